/* File: pwr_ctrl_pkg.sv */
package pwr_ctrl_pkg;

  // ==========================================================
  // clock and loop timing
  localparam int CLK_MHZ         = 20;
  localparam int LOOP_PERIOD_US  = 1000;  // loop update period, one millisecond
  localparam int LOOP_CYCLES_DEF = LOOP_PERIOD_US * CLK_MHZ;

  // ==========================================================
  // widths
  localparam int FREQ_W = 19;  // switching frequency in 0.5 Hz units
  localparam int DUTY_W = 13;  // duty in 0.01 % units
  localparam int CUR_W  = 16;  // coil current amplitude in 1 mA units
  localparam int ACC_W  = 24;  // signed loop arithmetic

  // ==========================================================
  // frequency limits and bands, 0.5 Hz units
  localparam logic [18:0] FREQ_MIN_HH   = 19'h3_5B60;  // 110 kHz
  localparam logic [18:0] FREQ_MAX_HH   = 19'h6_4190;  // 205 kHz
  localparam logic [18:0] FREQ_START_HH = 19'h5_5730;  // 175 kHz
  localparam logic [18:0] BAND1_TOP_HH  = 19'h4_45C0;  // 140 kHz
  localparam logic [18:0] BAND2_TOP_HH  = 19'h4_E200;  // 160 kHz
  localparam logic [18:0] BAND3_TOP_HH  = 19'h5_7E40;  // 180 kHz
  // output scaling per band, 0.5 Hz per loop unit
  localparam logic [3:0]  SCALE_B1 = 4'h3;  // 1.5 Hz
  localparam logic [3:0]  SCALE_B2 = 4'h4;  // 2 Hz
  localparam logic [3:0]  SCALE_B3 = 4'h6;  // 3 Hz
  localparam logic [3:0]  SCALE_B4 = 4'hA;  // 5 Hz

  // ==========================================================
  // duty limits, 0.01 % units
  localparam logic [12:0] DUTY_MAX  = 13'h1388;  // 50 %
  localparam logic [12:0] DUTY_MIN  = 13'h03E8;  // 10 %
  localparam logic [13:0] DUTY_FULL = 14'h2710;  // 100 %

  // ==========================================================
  // loop gains and limits
  localparam logic signed [23:0] GAIN_P      = 24'sh00_000A;  // proportional_gain 10
  localparam logic signed [23:0] GAIN_D      = 24'sh00_0000;  // derivative_gain 0
  localparam logic signed [23:0] INT_DIV     = 24'sh00_0014;  // integral_gain 1/20 per ms
  localparam logic signed [23:0] INT_LIMIT   = 24'sh00_0BB8;  // 3000
  localparam logic signed [23:0] IACC_LIMIT  = 24'sh00_EA60;  // 3000 * 20
  localparam logic signed [23:0] OUT_LIMIT   = 24'sh00_4E20;  // loop_output_clamp 20000

  // ==========================================================
  // phase accumulator: inc = freq_hh * mult >> shift
  localparam logic [15:0] PHASE_MULT  = 16'h6B5F;
  localparam int          PHASE_SHIFT = 8;

  // ==========================================================
  // register map (byte offsets) and fields
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_TARGET = 8'h04;
  localparam logic [7:0] OFS_FREQ   = 8'h08;
  localparam logic [7:0] OFS_DUTY   = 8'h0C;
  localparam logic [7:0] OFS_SENSE  = 8'h10;
  localparam logic [7:0] OFS_LOOP   = 8'h14;
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_MODE_BIT = 1;

  // ==========================================================
  // types
  typedef enum logic {MODE_FREQ, MODE_DUTY} ctrl_mode_e;
  typedef enum logic [1:0] {PS_IDLE, PS_START, PS_RUN} power_state_e;

  typedef struct packed {
    logic        run;
    logic [18:0] freq_hh;
    logic [12:0] duty;
  } drive_setting_s;

endpackage

/* File: sense_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module sense_sync #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  // asynchronous sample and its settled copy
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] value_o
);

  logic [W-1:0] s1_q, s2_q, s3_q, val_q;
  logic [W-1:0] val_d;

  // =========================================
  // accept a word only once stages two and three agree
  always_comb begin
    val_d = val_q;
    if (s2_q == s3_q) begin
      val_d = s3_q;
    end
  end

  // a multi-bit word can be caught mid-change; agreement filters that
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      val_q <= '0;
    end else begin
      s1_q  <= async_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      val_q <= val_d;
    end
  end

  assign value_o = val_q;

endmodule // sense_sync
`default_nettype wire

/* File: pwm_core.sv */
`timescale 1ns/1ps
`default_nettype none

module pwm_core (
  // clock and reset
  input  wire logic                           clk_i,
  input  wire logic                           arst_n_i,
  // setting to apply
  input  wire pwr_ctrl_pkg::drive_setting_s   setting_i,
  // bridge legs
  output logic                                leg_a_o,
  output logic                                leg_b_o
);

  logic [31:0] phase_q, phase_d;
  logic        leg_a_q, leg_a_d, leg_b_q, leg_b_d;
  logic [39:0] prod;
  logic [31:0] inc;
  logic [31:0] pos_scaled;
  logic [31:0] duty_scaled;
  logic        on_time;

  // =========================================
  // R04 fine phase step
  // 0.5 Hz frequency steps, far finer than the coarsest allowed step
  assign prod = 40'(setting_i.freq_hh) * 40'(pwr_ctrl_pkg::PHASE_MULT);
  assign inc  = prod[pwr_ctrl_pkg::PHASE_SHIFT +: 32];

  // R05 duty compare
  // each half period is active while its position is below the duty
  assign pos_scaled  = 32'({1'b0, phase_q[30:16]}) * 32'(pwr_ctrl_pkg::DUTY_FULL);
  assign duty_scaled = {3'b000, setting_i.duty, 16'h0000};
  assign on_time     = pos_scaled < duty_scaled;

  // R01 drive generation
  always_comb begin
    phase_d = '0;
    leg_a_d = 1'b0;
    leg_b_d = 1'b0;
    if (setting_i.run) begin
      phase_d = phase_q + inc;
      leg_a_d = ~phase_q[31] & on_time;
      leg_b_d = phase_q[31] & on_time;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_q <= '0;
      leg_a_q <= 1'b0;
      leg_b_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      leg_a_q <= leg_a_d;
      leg_b_q <= leg_b_d;
    end
  end

  assign leg_a_o = leg_a_q;
  assign leg_b_o = leg_b_q;

endmodule // pwm_core
`default_nettype wire

/* File: inverter_power_control_pid.sv */
// Notes on behaviour
// R01 - drive 110 to 205 kHz with 50 % duty across that span
// R02 - only at 205 kHz may duty drop, down to 10 %
// R03 - higher frequency or lower duty means less power, and vice versa
// R04 - frequency step no coarser than the band-dependent resolution formulas
// R05 - duty step 0.1 % or finer
// R06 - every power start begins at 175 kHz and 50 % duty
// R07 - loop output steers either frequency or duty
// R08 - coil current amplitude measured to 7 mA or finer
// R09 - frequency loop gains 10, 0.05, 0; integral 3000, output 20000 limits
// R10 - duty loop same gains and limits; output scales -0.01 % per unit
// R11 - frequency scaling 1.5, 2, 3, 5 Hz by band
// R12 - receiver message targets feed the loop that drives the inverter
// R13 - clamp every new frequency and duty before applying it
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

module inverter_power_control_pid #(
  parameter int LOOP_CYCLES = pwr_ctrl_pkg::LOOP_CYCLES_DEF
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // receiver message decoder
  input  wire logic        target_valid_i,
  input  wire logic [15:0] target_ma_i,
  // coil current sense
  input  wire logic [15:0] sense_ma_i,
  // bridge legs
  output logic             leg_a_o,
  output logic             leg_b_o
);

  // every package item below is reached by its full scoped name

  // =========================================
  // state
  pwr_ctrl_pkg::power_state_e     state_q, state_d;
  pwr_ctrl_pkg::drive_setting_s   drv_q, drv_d;
  logic                           en_q, en_d;
  pwr_ctrl_pkg::ctrl_mode_e       mode_q, mode_d;
  logic [15:0]                    target_q, target_d;
  logic signed [23:0]             iacc_q, iacc_d;
  logic signed [23:0]             err_prev_q, err_prev_d;
  logic signed [23:0]             out_q, out_d;
  logic [31:0]                    tick_cnt_q, tick_cnt_d;
  logic                           tick;
  logic [15:0]                    sense_ma;
  logic [31:0]                    prdata_q, prdata_d;
  logic                           pready_q, pready_d;
  logic                           pslverr_q, pslverr_d;
  logic                           wr_take;

  // loop arithmetic
  logic signed [23:0] err, iacc_sum, iacc_clamped, iterm, pid_sum, pid_clamped;
  logic signed [23:0] freq_step, freq_new, duty_new;
  logic [3:0]         scale;
  logic [12:0]        duty_floor;

  // =========================================
  // R08 current sense capture
  // 1 mA units, well below the 7 mA needed
  sense_sync #(
    .W (16)
  ) u_sense (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .async_i  (sense_ma_i),
    .value_o  (sense_ma)
  );

  // =========================================
  // apb answer: zero wait states, answered in the first access cycle
  always_comb begin
    pready_d  = psel_i & ~penable_i;
    pslverr_d = 1'b0;
    prdata_d  = '0;
    if (psel_i && !penable_i) begin
      case (paddr_i)
        pwr_ctrl_pkg::OFS_CTRL:   prdata_d = {30'h0000_0000, mode_q, en_q};
        pwr_ctrl_pkg::OFS_TARGET: prdata_d = {16'h0000, target_q};
        pwr_ctrl_pkg::OFS_FREQ:   prdata_d = {13'h0000, drv_q.freq_hh};
        pwr_ctrl_pkg::OFS_DUTY:   prdata_d = {19'h0_0000, drv_q.duty};
        pwr_ctrl_pkg::OFS_SENSE:  prdata_d = {16'h0000, sense_ma};
        pwr_ctrl_pkg::OFS_LOOP:   prdata_d = 32'(out_q);
        default:                  pslverr_d = 1'b1;
      endcase
      if (pwrite_i) begin
        prdata_d = '0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign wr_take = psel_i & penable_i & pwrite_i & pready_q & ~pslverr_q;

  // =========================================
  // loop tick divider, restarted at power start so the first update sees settled sense
  always_comb begin
    tick       = tick_cnt_q == 32'(LOOP_CYCLES - 1);
    tick_cnt_d = (tick || state_q == pwr_ctrl_pkg::PS_START) ? '0 : tick_cnt_q + 32'h0000_0001;
  end

  // =========================================
  // pid arithmetic, combinational from registered state
  always_comb begin
    // error positive when coil current is above target
    err = 24'($signed({1'b0, sense_ma})) - 24'($signed({1'b0, target_q}));
    iacc_sum = iacc_q + err;
    // R09 integral limit
    if (iacc_sum > pwr_ctrl_pkg::IACC_LIMIT) begin
      iacc_clamped = pwr_ctrl_pkg::IACC_LIMIT;
    end else if (iacc_sum < -pwr_ctrl_pkg::IACC_LIMIT) begin
      iacc_clamped = -pwr_ctrl_pkg::IACC_LIMIT;
    end else begin
      iacc_clamped = iacc_sum;
    end
    iterm   = iacc_clamped / pwr_ctrl_pkg::INT_DIV;
    pid_sum = pwr_ctrl_pkg::GAIN_P * err + iterm
            + pwr_ctrl_pkg::GAIN_D * (err - err_prev_q);
    // R09 output clamp
    if (pid_sum > pwr_ctrl_pkg::OUT_LIMIT) begin
      pid_clamped = pwr_ctrl_pkg::OUT_LIMIT;
    end else if (pid_sum < -pwr_ctrl_pkg::OUT_LIMIT) begin
      pid_clamped = -pwr_ctrl_pkg::OUT_LIMIT;
    end else begin
      pid_clamped = pid_sum;
    end
    // R11 band scaling
    if (drv_q.freq_hh < pwr_ctrl_pkg::BAND1_TOP_HH) begin
      scale = pwr_ctrl_pkg::SCALE_B1;
    end else if (drv_q.freq_hh < pwr_ctrl_pkg::BAND2_TOP_HH) begin
      scale = pwr_ctrl_pkg::SCALE_B2;
    end else if (drv_q.freq_hh < pwr_ctrl_pkg::BAND3_TOP_HH) begin
      scale = pwr_ctrl_pkg::SCALE_B3;
    end else begin
      scale = pwr_ctrl_pkg::SCALE_B4;
    end
    // R03 more output, higher frequency, less power
    freq_step = pid_clamped * $signed({20'h0_0000, scale});
    freq_new  = $signed({5'h00, drv_q.freq_hh}) + freq_step;
    // R10 duty scaling
    // minus 0.01 % per unit: more output, lower duty
    duty_new  = $signed({11'h000, drv_q.duty}) - pid_clamped;
    // R02 duty floor
    // below the top frequency duty is pinned at 50 %
    duty_floor = (drv_q.freq_hh == pwr_ctrl_pkg::FREQ_MAX_HH) ?
                 pwr_ctrl_pkg::DUTY_MIN : pwr_ctrl_pkg::DUTY_MAX;
  end

  // =========================================
  // control registers, power sequencing and setting update
  always_comb begin
    state_d    = state_q;
    drv_d      = drv_q;
    en_d       = en_q;
    mode_d     = mode_q;
    target_d   = target_q;
    iacc_d     = iacc_q;
    err_prev_d = err_prev_q;
    out_d      = out_q;
    if (wr_take && paddr_i == pwr_ctrl_pkg::OFS_CTRL) begin
      en_d   = pwdata_i[pwr_ctrl_pkg::CTRL_EN_BIT];
      mode_d = pwr_ctrl_pkg::ctrl_mode_e'(pwdata_i[pwr_ctrl_pkg::CTRL_MODE_BIT]);
    end
    if (wr_take && paddr_i == pwr_ctrl_pkg::OFS_TARGET) begin
      target_d = pwdata_i[15:0];
    end
    // R12 receiver target
    // decoder update wins over a software write in the same cycle
    if (target_valid_i) begin
      target_d = target_ma_i;
    end
    case (state_q)
      pwr_ctrl_pkg::PS_IDLE: begin
        drv_d.run = 1'b0;
        if (en_q) begin
          state_d = pwr_ctrl_pkg::PS_START;
        end
      end
      // R06 initial setting
      pwr_ctrl_pkg::PS_START: begin
        drv_d.run     = 1'b1;
        drv_d.freq_hh = pwr_ctrl_pkg::FREQ_START_HH;
        drv_d.duty    = pwr_ctrl_pkg::DUTY_MAX;
        iacc_d        = '0;
        err_prev_d    = '0;
        out_d         = '0;
        state_d       = pwr_ctrl_pkg::PS_RUN;
      end
      pwr_ctrl_pkg::PS_RUN: begin
        if (!en_q) begin
          drv_d.run = 1'b0;
          state_d   = pwr_ctrl_pkg::PS_IDLE;
        end else if (tick) begin
          iacc_d     = iacc_clamped;
          err_prev_d = err;
          out_d      = pid_clamped;
          // R07 steer frequency or duty
          if (mode_q == pwr_ctrl_pkg::MODE_FREQ) begin
            // R13 frequency clamp
            if (freq_new > $signed({5'h00, pwr_ctrl_pkg::FREQ_MAX_HH})) begin
              drv_d.freq_hh = pwr_ctrl_pkg::FREQ_MAX_HH;
            end else if (freq_new < $signed({5'h00, pwr_ctrl_pkg::FREQ_MIN_HH})) begin
              drv_d.freq_hh = pwr_ctrl_pkg::FREQ_MIN_HH;
            end else begin
              drv_d.freq_hh = freq_new[18:0];
            end
            drv_d.duty = pwr_ctrl_pkg::DUTY_MAX;
          end else begin
            // R13 duty clamp
            if (duty_new > $signed({11'h000, pwr_ctrl_pkg::DUTY_MAX})) begin
              drv_d.duty = pwr_ctrl_pkg::DUTY_MAX;
            end else if (duty_new < $signed({11'h000, duty_floor})) begin
              drv_d.duty = duty_floor;
            end else begin
              drv_d.duty = duty_new[12:0];
            end
          end
        end
      end
      default: begin
        state_d   = pwr_ctrl_pkg::PS_IDLE;
        drv_d.run = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q    <= pwr_ctrl_pkg::PS_IDLE;
      drv_q      <= '{run: 1'b0, freq_hh: pwr_ctrl_pkg::FREQ_START_HH,
                      duty: pwr_ctrl_pkg::DUTY_MAX};
      en_q       <= 1'b0;
      mode_q     <= pwr_ctrl_pkg::MODE_FREQ;
      target_q   <= '0;
      iacc_q     <= '0;
      err_prev_q <= '0;
      out_q      <= '0;
      tick_cnt_q <= '0;
    end else begin
      state_q    <= state_d;
      drv_q      <= drv_d;
      en_q       <= en_d;
      mode_q     <= mode_d;
      target_q   <= target_d;
      iacc_q     <= iacc_d;
      err_prev_q <= err_prev_d;
      out_q      <= out_d;
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // =========================================
  // waveform generator
  pwm_core u_pwm (
    .clk_i     (clk_i),
    .arst_n_i  (arst_n_i),
    .setting_i (drv_q),
    .leg_a_o   (leg_a_o),
    .leg_b_o   (leg_b_o)
  );

  assign prdata_o  = prdata_q;
  assign pready_o  = pready_q;
  assign pslverr_o = pslverr_q;

  // =========================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_start;
    state_q == pwr_ctrl_pkg::PS_START;
  endsequence

  AST_APB_ANSWER: assert property (s_setup |=> pready_o) // implementation choice, apb port
    else $error("apb access not answered in first access cycle");
  AST_FREQ_RANGE: assert property (drv_q.run |-> // R01
      drv_q.freq_hh >= pwr_ctrl_pkg::FREQ_MIN_HH && drv_q.freq_hh <= pwr_ctrl_pkg::FREQ_MAX_HH)
    else $error("frequency outside allowed span");
  AST_DUTY_PINNED: assert property (drv_q.run && drv_q.freq_hh != pwr_ctrl_pkg::FREQ_MAX_HH // R02
      |-> drv_q.duty == pwr_ctrl_pkg::DUTY_MAX)
    else $error("duty reduced below top frequency");
  AST_DUTY_RANGE: assert property (drv_q.duty >= pwr_ctrl_pkg::DUTY_MIN // R13
      && drv_q.duty <= pwr_ctrl_pkg::DUTY_MAX)
    else $error("duty outside allowed range");
  AST_START: assert property (s_start ##1 1'b1 |-> // R06
      drv_q.run && drv_q.freq_hh == pwr_ctrl_pkg::FREQ_START_HH
      && drv_q.duty == pwr_ctrl_pkg::DUTY_MAX)
    else $error("power start not at initial setting");
  AST_FREQ_DIR: assert property (state_q == pwr_ctrl_pkg::PS_RUN && en_q && tick // R03
      && mode_q == pwr_ctrl_pkg::MODE_FREQ && pid_clamped > 0
      |=> drv_q.freq_hh >= $past(drv_q.freq_hh))
    else $error("positive loop output lowered frequency");
  AST_INT_LIMIT: assert property (iacc_q <= pwr_ctrl_pkg::IACC_LIMIT // R09
      && iacc_q >= -pwr_ctrl_pkg::IACC_LIMIT)
    else $error("integral accumulator beyond limit");
  AST_OUT_LIMIT: assert property (out_q <= pwr_ctrl_pkg::OUT_LIMIT // R10
      && out_q >= -pwr_ctrl_pkg::OUT_LIMIT)
    else $error("loop output beyond clamp");
  AST_BAND_STEP: assert property (state_q == pwr_ctrl_pkg::PS_RUN && en_q && tick // R11
      && mode_q == pwr_ctrl_pkg::MODE_FREQ && drv_q.freq_hh < pwr_ctrl_pkg::BAND1_TOP_HH
      && freq_new <= $signed({5'h00, pwr_ctrl_pkg::FREQ_MAX_HH})
      && freq_new >= $signed({5'h00, pwr_ctrl_pkg::FREQ_MIN_HH})
      |=> 24'($signed({5'h00, drv_q.freq_hh})) - 24'($signed({5'h00, $past(drv_q.freq_hh)}))
          == 24'sh00_0003 * $past(pid_clamped))
    else $error("lowest band scaling not 1.5 Hz per unit");

endmodule // inverter_power_control_pid
`default_nettype wire

/* File: coil_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// bridge and coil stand-in: reports the commanded
// coil current only while the legs are switching
module coil_stage_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // bridge legs and commanded amplitude
  input  wire logic        leg_a_i,
  input  wire logic        leg_b_i,
  input  wire logic [15:0] level_ma_i,
  // sensed amplitude
  output logic      [15:0] sense_ma_o
);
  logic [7:0] idle_q;

  // a dead bridge carries no current, so the sense reads zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idle_q <= 8'h00;
    end else if (leg_a_i || leg_b_i) begin
      idle_q <= 8'hFF;
    end else if (idle_q != 8'h00) begin
      idle_q <= idle_q - 8'h01;
    end
  end

  assign sense_ma_o = (idle_q != 8'h00) ? level_ma_i : 16'h0000;
endmodule  // coil_stage_model

`default_nettype wire

/* File: test_inverter_power_control_pid.sv */
`timescale 1ns/1ps
`default_nettype none

module test_inverter_power_control_pid;
  localparam int LC = 20;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic        tvalid, leg_a, leg_b, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] target, sense, level;
  int          failures, checks;

  // ==========================================
  // design and partner
  inverter_power_control_pid #(.LOOP_CYCLES(LC)) inverter_power_control_pid_inst (
    .clk_i(clk), .arst_n_i(arst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .target_valid_i(tvalid),
    .target_ma_i(target), .sense_ma_i(sense), .leg_a_o(leg_a), .leg_b_o(leg_b));
  coil_stage_model coil_stage_model_inst (
    .clk_i(clk), .arst_n_i(arst_n), .leg_a_i(leg_a), .leg_b_i(leg_b),
    .level_ma_i(level), .sense_ma_o(sense));

  // ==========================================
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // whole run is near 10500 cycles; this leaves wide margin
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    conclude();
  end

  // ==========================================
  // shared tasks
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // apb transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // a hung slave is caught by the watchdog only
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, exp, rd);
  endtask

  task automatic set_target(input logic [15:0] v);
    target <= v;
    tvalid <= 1'b1;
    @(posedge clk);
    tvalid <= 1'b0;
  endtask

  // 2000 cycles: count leg_a rises and high cycles, and leg overlap
  task automatic measure(input string name, input int lo, input int hi, input int hmin,
                         input int hmax);
    int rises, highs, both;
    logic prev;
    rises = 0;
    highs = 0;
    both = 0;
    prev = leg_a;
    repeat (2000) begin
      @(posedge clk);
      if (leg_a === 1'b1 && prev !== 1'b1) rises++;
      if (leg_a === 1'b1) highs++;
      if (leg_a === 1'b1 && leg_b === 1'b1) both++;
      prev = leg_a;
    end
    chk({name, " rate"}, 1, 32'(rises >= lo && rises <= hi));
    chk({name, " duty"}, 1, 32'(highs >= hmin && highs <= hmax));
    chk({name, " overlap"}, 0, both);
  endtask

  // ==========================================
  // scenarios
  task automatic t_reset();
    chk("legs idle", 0, {leg_a, leg_b});
    rdchk("ctrl reset", pwr_ctrl_pkg::OFS_CTRL, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
  endtask

  task automatic t_start();
    level <= 16'h012C;
    apb(1'b1, pwr_ctrl_pkg::OFS_TARGET, 32'h0000_012C);
    rdchk("target", pwr_ctrl_pkg::OFS_TARGET, 32'h0000_012C);
    apb(1'b1, pwr_ctrl_pkg::OFS_CTRL, 32'h0000_0001);
    rdchk("start freq", pwr_ctrl_pkg::OFS_FREQ, 32'h0005_5730);
    rdchk("start duty", pwr_ctrl_pkg::OFS_DUTY, 32'h0000_1388);
    measure("175k", 16, 19, 900, 1100);
  endtask

  // band step, 3 Hz per unit from 160 to 180 kHz
  task automatic t_step();
    logic [31:0] f0;
    level <= 16'h012D;
    repeat (2 * LC) @(posedge clk);
    apb(1'b0, pwr_ctrl_pkg::OFS_FREQ, 32'h0000_0000);
    f0 = rd;
    // gain 10 times 6 half-Hz per unit: every step is a multiple of 60
    chk("step base", 1, 32'(f0 > 32'h0005_5730 && (f0 - 32'h0005_5730) % 60 == 0));
    repeat (6 * LC) @(posedge clk);
    apb(1'b0, pwr_ctrl_pkg::OFS_FREQ, 32'h0000_0000);
    chk("step size", 1, 32'((rd > f0) && ((rd - f0) % 60 == 0)));
  endtask

  task automatic t_sweep();
    set_target(16'h0064);
    level <= 16'h0FA0;
    repeat (10 * LC) @(posedge clk);
    rdchk("freq top", pwr_ctrl_pkg::OFS_FREQ, 32'h0006_4190);
    rdchk("loop clamp", pwr_ctrl_pkg::OFS_LOOP, 32'h0000_4E20);
    measure("205k", 19, 22, 900, 1100);
    apb(1'b1, pwr_ctrl_pkg::OFS_CTRL, 32'h0000_0003);
    repeat (10 * LC) @(posedge clk);
    rdchk("duty floor", pwr_ctrl_pkg::OFS_DUTY, 32'h0000_03E8);
    rdchk("freq kept", pwr_ctrl_pkg::OFS_FREQ, 32'h0006_4190);
    measure("10pct", 19, 22, 100, 300);
    apb(1'b1, pwr_ctrl_pkg::OFS_CTRL, 32'h0000_0001);
    set_target(16'h0FA0);
    level <= 16'h0000;
    repeat (30 * LC) @(posedge clk);
    rdchk("freq bottom", pwr_ctrl_pkg::OFS_FREQ, 32'h0003_5B60);
    rdchk("duty back", pwr_ctrl_pkg::OFS_DUTY, 32'h0000_1388);
    rdchk("loop neg", pwr_ctrl_pkg::OFS_LOOP, 32'hFFFF_B1E0);
    measure("110k", 10, 12, 900, 1100);
    apb(1'b1, pwr_ctrl_pkg::OFS_CTRL, 32'h0000_0003);
    set_target(16'h0064);
    level <= 16'h0FA0;
    repeat (10 * LC) @(posedge clk);
    rdchk("duty held", pwr_ctrl_pkg::OFS_DUTY, 32'h0000_1388);
    rdchk("freq held", pwr_ctrl_pkg::OFS_FREQ, 32'h0003_5B60);
  endtask

  task automatic t_restart();
    level <= 16'h0064;
    apb(1'b1, pwr_ctrl_pkg::OFS_CTRL, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk("legs stop", 0, {leg_a, leg_b});
    apb(1'b1, pwr_ctrl_pkg::OFS_CTRL, 32'h0000_0001);
    // start setting lands two edges after the enable write
    @(posedge clk);
    rdchk("restart freq", pwr_ctrl_pkg::OFS_FREQ, 32'h0005_5730);
    rdchk("restart duty", pwr_ctrl_pkg::OFS_DUTY, 32'h0000_1388);
    // under-current walks the frequency down through the three lower bands to the floor
    level <= 16'h0000;
    repeat (50 * LC) @(posedge clk);
    rdchk("freq descent", pwr_ctrl_pkg::OFS_FREQ, 32'h0003_5B60);
  endtask

  // ==========================================
  // main sequence
  initial begin
    failures = 0;
    checks = 0;
    arst_n = 1'b0;
    {psel, penable, pwrite, tvalid} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    target = 16'h0000;
    level = 16'h0000;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_start();
    t_step();
    t_sweep();
    t_restart();
    conclude();
  end
endmodule  // test_inverter_power_control_pid

`default_nettype wire
